// ==== hdl/oms_pkg.sv ====
/*
  oms_pkg: command codes, sizes and slot timing for the single-wire
  OTP memory host sequencer. Assumes a 50 MHz clock.
*/
package oms_pkg;
  typedef enum logic [1:0] {OP_RD_FIELD, OP_WR_MEM, OP_RD_STAT, OP_WR_STAT} oms_op_t;
  typedef enum logic [1:0] {BOP_RESET, BOP_WR0, BOP_WR1, BOP_RD} oms_bop_t;

  localparam logic [7:0]  CMD_SKIP_SEL  = 8'hcc;
  localparam logic [7:0]  CMD_RD_FIELD  = 8'hf0;
  localparam logic [7:0]  CMD_WR_MEM    = 8'h0f;
  localparam logic [7:0]  CMD_RD_STAT   = 8'haa;
  localparam logic [7:0]  CMD_WR_STAT   = 8'h55;
  localparam logic [7:0]  CMD_PROG      = 8'h5a;
  localparam logic [7:0]  CRC_POLY_REFL = 8'h8c;
  localparam logic [7:0]  MEM_BYTES     = 8'h80;
  localparam logic [7:0]  STAT_BYTES    = 8'h08;
  localparam logic [3:0]  SEG_BYTES     = 4'h8;
  localparam logic [15:0] WR_ADDR_MAX   = 16'h007f;
  localparam logic [1:0]  MAX_RETRY     = 2'h3;

  localparam int CLK_MHZ        = 50;
  localparam int T_STROBE_NS    = 1000;
  localparam int T_SLOT_NS      = 60000;
  localparam int T_SAMPLE_NS    = 15000;
  localparam int T_RECOV_NS     = 5000;
  localparam int T_PULSE_A_NS   = 70000;
  localparam int T_RESET_LOW_NS = 480000;
  localparam int T_RESET_HI_NS  = 480000;
  localparam int EPROM_PROGRAM_PULSE_TIME_NS = 2500000;

  // least times round up, sample points round down
  localparam int STROBE_CYC  = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SLOT_CYC    = (T_SLOT_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_CYC  = (T_SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int RECOV_CYC   = (T_RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_A_CYC = (T_PULSE_A_NS * CLK_MHZ) / 1000;
  localparam int RESET_LOW_CYC_DEF = (T_RESET_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_HI_CYC_DEF  = (T_RESET_HI_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_CYC_DEF = (EPROM_PROGRAM_PULSE_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage

// ==== hdl/oms_crc8.sv ====
/*
  oms_crc8: bit-serial CRC (x^8+x^5+x^4+1), lsb first.
  Assumes the sequencer feeds every link bit of a covered field.
*/
`timescale 1ns/10ps
module oms_crc8 import oms_pkg::*; (
  // clock
  input  logic       clk,
  input  logic       resetn,
  input  logic       ce,
  // control
  input  logic       clr,
  input  logic       shift,
  input  logic       din,
  // result
  output logic [7:0] crc,
  output logic       zero_next
);
  typedef struct packed {logic [7:0] crc;} oms_crc_st_t;
  oms_crc_st_t s, n;
  logic [7:0]  nx;

  always_comb begin
    nx = {1'b0, s.crc[7:1]} ^ ((s.crc[0] ^ din) ? CRC_POLY_REFL : 8'h00);
    n = s;
    if (clr) begin
      n.crc = 8'h00;
    end else if (shift) begin
      n.crc = nx;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign crc = s.crc;
  // shifting a received crc into its own remainder leaves zero
  assign zero_next = (nx == 8'h00);

  a_crc_poly_step: assert property (@(posedge clk) disable iff (!resetn)
    ce && shift && !clr && (s.crc[0] ^ din) |=> crc == (($past(crc) >> 1) ^ CRC_POLY_REFL))
    else $error("crc step does not follow the polynomial");
endmodule // oms_crc8

// ==== hdl/oms_bit_slot.sv ====
/*
  oms_bit_slot: one reset or bit slot on the open-drain line per request.
  Assumes an external pull-up; dq_in is asynchronous to clk.
*/
`timescale 1ns/10ps
module oms_bit_slot import oms_pkg::*; #(
  parameter int unsigned RESET_LOW_CYC = RESET_LOW_CYC_DEF,
  parameter int unsigned RESET_HI_CYC  = RESET_HI_CYC_DEF,
  // shrinks every bit-slot count and the reset answer sample point together, not the reset low and high counts; 1 keeps the package timing
  parameter int unsigned TIME_DIV      = 1
) (
  // clock
  input  logic     clk,
  input  logic     resetn,
  input  logic     ce,
  // request
  input  logic     req,
  input  oms_bop_t op,
  output logic     done,
  output logic     rbit,
  // line
  input  logic     dq_in,
  output logic     dq_out,
  output logic     dq_oe
);
  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_REL} oms_ph_t;
  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    oms_ph_t     ph;
    oms_bop_t    op;
    logic [16:0] cnt;
    logic        oe;
    logic        done;
    logic        rbit;
  } oms_bit_st_t;
  oms_bit_st_t s, n;
  logic [16:0] low_end, rel_end, smp;

  // slot counts scaled as one so strobe, sample and recovery keep their order
  localparam int unsigned STB = STROBE_CYC / TIME_DIV;
  localparam int unsigned SLT = SLOT_CYC / TIME_DIV;
  localparam int unsigned SMP = SAMPLE_CYC / TIME_DIV;
  localparam int unsigned RCV = RECOV_CYC / TIME_DIV;
  localparam int unsigned ANS = PULSE_A_CYC / TIME_DIV;

  always_comb begin
    n = s;
    n.done = 1'b0;
    n.sync = {s.sync[1:0], dq_in};
    // level only changes once second and third stage agree
    if (s.sync[1] == s.sync[2]) begin
      n.lvl = s.sync[2];
    end
    case (s.op)
      BOP_RESET: begin
        low_end = 17'(RESET_LOW_CYC - 1);
        rel_end = 17'(RESET_HI_CYC - 1);
        smp     = 17'(ANS);
      end
      BOP_WR0: begin
        low_end = 17'(SLT - RCV - 1);
        rel_end = 17'(RCV - 1);
        smp     = 17'(RCV - 1);
      end
      default: begin
        low_end = 17'(STB - 1);
        rel_end = 17'(SLT - STB - 1);
        smp     = 17'(SMP - STB);
      end
    endcase
    case (s.ph)
      PH_IDLE: if (req) begin
        n.op  = op;
        n.oe  = 1'b1;
        n.cnt = '0;
        n.ph  = PH_LOW;
      end
      PH_LOW: if (s.cnt == low_end) begin
        n.oe  = 1'b0;
        n.cnt = '0;
        n.ph  = PH_REL;
      end else begin
        n.cnt = s.cnt + 17'h1;
      end
      PH_REL: begin
        // line low after a reset means a slave answered
        if (s.cnt == smp) begin
          n.rbit = (s.op == BOP_RESET) ? ~s.lvl : s.lvl;
        end
        if (s.cnt == rel_end) begin
          n.done = 1'b1;
          n.ph   = PH_IDLE;
        end else begin
          n.cnt = s.cnt + 17'h1;
        end
      end
      default: n.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign done   = s.done;
  assign rbit   = s.rbit;
  assign dq_oe  = s.oe;
  assign dq_out = 1'b0;

  logic [16:0] lowcnt;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lowcnt <= '0;
    end else if (ce) begin
      lowcnt <= s.oe ? lowcnt + 17'h1 : 17'h0;
    end
  end

  a_reset_low_len: assert property (@(posedge clk) disable iff (!resetn)
    $fell(s.oe) && s.op == BOP_RESET |-> lowcnt == 17'(RESET_LOW_CYC))
    else $error("reset low time wrong");
  a_read_strobe_len: assert property (@(posedge clk) disable iff (!resetn)
    $fell(s.oe) && s.op == BOP_RD |-> lowcnt == 17'(STB))
    else $error("read strobe length wrong");
endmodule // oms_bit_slot

// ==== hdl/oms_seq.sv ====
/*
  oms_seq: host sequencer for a single-wire OTP memory slave: field read,
  segment write, status read and status write, with crc checks and retry.
  Assumes one slave on the line, an external pull-up and an external switch
  that puts programming voltage on the line while vpp_en is high.
*/
`timescale 1ns/10ps
module oms_seq import oms_pkg::*; #(
  parameter int unsigned RESET_LOW_CYC = RESET_LOW_CYC_DEF,
  parameter int unsigned RESET_HI_CYC  = RESET_HI_CYC_DEF,
  parameter int unsigned PROG_CYC      = PROG_CYC_DEF,
  parameter int unsigned TIME_DIV      = 1
) (
  // clock
  input  logic        clk,
  input  logic        resetn,
  input  logic        ce,
  // user command
  input  logic        start,
  input  oms_op_t     op,
  input  logic [15:0] addr,
  input  logic [63:0] wdata,
  output logic        busy,
  output logic        done,
  output logic        ok,
  // read stream
  output logic        rd_valid,
  output logic [7:0]  rd_data,
  // line
  input  logic        dq_in,
  output logic        dq_out,
  output logic        dq_oe,
  output logic        vpp_en
);
  typedef enum logic [3:0] {
    S_IDLE, S_RST, S_SEL, S_CMD, S_ALO, S_AHI, S_WDAT, S_HCRC,
    S_DCRC, S_RDAT, S_FCRC, S_PCMD, S_PULSE, S_FIN
  } oms_state_t;
  typedef struct packed {
    oms_state_t  st;
    oms_op_t     op;
    logic [15:0] addr;
    logic [15:0] addr0;
    logic [63:0] wbuf;
    logic [2:0]  widx;
    logic [7:0]  sh;
    logic [2:0]  bitn;
    logic [7:0]  nbytes;
    logic [1:0]  retry;
    logic [16:0] cnt;
    logic        breq;
    oms_bop_t    bop;
    logic        busy;
    logic        done;
    logic        ok;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        vpp;
  } oms_seq_st_t;
  oms_seq_st_t s, n;

  logic       bit_done, rbit, crc_zero, crc_clr, crc_shift, crc_din;
  logic [7:0] crc_val, ld_val, lim, slim, cmd_code, rbyte;
  logic       ld, ld_rx, ld_rst, rx, byte_end, fail, bad;

  oms_bit_slot #(
    .RESET_LOW_CYC (RESET_LOW_CYC),
    .RESET_HI_CYC  (RESET_HI_CYC),
    .TIME_DIV      (TIME_DIV)
  ) u_bit (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .req    (s.breq),
    .op     (s.bop),
    .done   (bit_done),
    .rbit   (rbit),
    .dq_in  (dq_in),
    .dq_out (dq_out),
    .dq_oe  (dq_oe)
  );

  oms_crc8 u_crc (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .clr       (crc_clr),
    .shift     (crc_shift),
    .din       (crc_din),
    .crc       (crc_val),
    .zero_next (crc_zero)
  );

  always_comb begin
    n = s;
    n.breq = 1'b0;
    n.done = 1'b0;
    n.rd_valid = 1'b0;
    crc_clr = 1'b0;
    crc_shift = 1'b0;
    crc_din = 1'b0;
    ld = 1'b0;
    ld_val = 8'h00;
    ld_rx = 1'b0;
    ld_rst = 1'b0;
    byte_end = 1'b0;
    fail = 1'b0;
    rx = (s.st == S_HCRC) || (s.st == S_DCRC) || (s.st == S_RDAT) || (s.st == S_FCRC);
    // status field is 8 bytes, the last one the fixed 00h byte
    lim = (op == OP_RD_STAT || op == OP_WR_STAT) ? STAT_BYTES : MEM_BYTES;
    // stream length must follow the accepted command, not the live op input
    slim = (s.op == OP_RD_STAT || s.op == OP_WR_STAT) ? STAT_BYTES : MEM_BYTES;
    rbyte = {rbit, s.sh[7:1]};
    case (s.op)
      OP_RD_FIELD: cmd_code = CMD_RD_FIELD;
      OP_WR_MEM:   cmd_code = CMD_WR_MEM;
      OP_RD_STAT:  cmd_code = CMD_RD_STAT;
      default:     cmd_code = CMD_WR_STAT;
    endcase
    bad = (op == OP_WR_MEM) ? (addr[2:0] != 3'h0 || addr > WR_ADDR_MAX)
                            : (addr >= {8'h00, lim});
    if (bit_done && s.st != S_RST && s.st != S_FIN && s.st != S_IDLE) begin
      crc_shift = 1'b1;
      crc_din = rx ? rbit : s.sh[0];
      n.sh = {rx ? rbit : 1'b0, s.sh[7:1]};
      if (s.bitn == 3'h7) begin
        byte_end = 1'b1;
      end else begin
        n.bitn = s.bitn + 3'h1;
        n.breq = 1'b1;
        n.bop = rx ? BOP_RD : (s.sh[1] ? BOP_WR1 : BOP_WR0);
      end
    end
    case (s.st)
      S_IDLE: if (start) begin
        n.op = op;
        n.addr = addr;
        n.addr0 = addr;
        n.wbuf = wdata;
        n.retry = 2'h0;
        n.ok = 1'b0;
        if (bad) begin
          n.done = 1'b1;
        end else begin
          n.busy = 1'b1;
          n.st = S_RST;
          ld = 1'b1;
          ld_rst = 1'b1;
        end
      end
      S_RST: if (bit_done) begin
        if (!rbit) begin
          n.done = 1'b1;
          n.busy = 1'b0;
          n.st = S_IDLE;
        end else begin
          n.st = S_SEL;
          ld = 1'b1;
          ld_val = CMD_SKIP_SEL;
        end
      end
      S_SEL: if (byte_end) begin
        n.st = S_CMD;
        ld = 1'b1;
        ld_val = cmd_code;
        crc_clr = 1'b1;
      end
      S_CMD: if (byte_end) begin
        n.st = S_ALO;
        ld = 1'b1;
        ld_val = s.addr[7:0];
      end
      S_ALO: if (byte_end) begin
        n.st = S_AHI;
        ld = 1'b1;
        ld_val = s.addr[15:8];
      end
      S_AHI: if (byte_end) begin
        ld = 1'b1;
        n.widx = 3'h0;
        if (s.op == OP_WR_STAT) begin
          n.st = S_WDAT;
          n.nbytes = 8'h01;
          ld_val = s.wbuf[7:0];
        end else begin
          n.st = S_HCRC;
          ld_rx = 1'b1;
        end
      end
      S_WDAT: if (byte_end) begin
        ld = 1'b1;
        n.widx = s.widx + 3'h1;
        if (s.nbytes == 8'h01) begin
          n.st = (s.op == OP_WR_STAT) ? S_HCRC : S_DCRC;
          ld_rx = 1'b1;
        end else begin
          n.nbytes = s.nbytes - 8'h01;
          ld_val = s.wbuf[{s.widx + 3'h1, 3'h0} +: 8];
        end
      end
      S_HCRC: if (byte_end) begin
        if (!crc_zero) begin
          fail = 1'b1;
        end else begin
          ld = 1'b1;
          crc_clr = 1'b1;
          case (s.op)
            OP_WR_MEM: begin
              n.st = S_WDAT;
              n.nbytes = {4'h0, SEG_BYTES};
              ld_val = s.wbuf[7:0];
            end
            OP_WR_STAT: begin
              n.st = S_PCMD;
              ld_val = CMD_PROG;
            end
            default: begin
              n.st = S_RDAT;
              n.nbytes = slim - s.addr[7:0];
              ld_rx = 1'b1;
            end
          endcase
        end
      end
      S_RDAT: if (byte_end) begin
        n.rd_valid = 1'b1;
        n.rd_data = rbyte;
        n.addr = s.addr + 16'h0001;
        ld = 1'b1;
        ld_rx = 1'b1;
        if (s.nbytes == 8'h01) begin
          n.st = S_FCRC;
        end else begin
          n.nbytes = s.nbytes - 8'h01;
        end
      end
      S_FCRC, S_DCRC: if (byte_end) begin
        if (!crc_zero) begin
          fail = 1'b1;
        end else if (s.st == S_FCRC) begin
          n.ok = 1'b1;
          n.st = S_FIN;
          ld = 1'b1;
          ld_rst = 1'b1;
        end else begin
          n.st = S_PCMD;
          ld = 1'b1;
          ld_val = CMD_PROG;
        end
      end
      S_PCMD: if (byte_end) begin
        n.st = S_PULSE;
        n.vpp = 1'b1;
        n.cnt = '0;
      end
      S_PULSE: if (s.cnt == 17'(PROG_CYC - 1)) begin
        n.vpp = 1'b0;
        n.ok = 1'b1;
        n.st = S_FIN;
        ld = 1'b1;
        ld_rst = 1'b1;
      end else begin
        n.cnt = s.cnt + 17'h1;
      end
      S_FIN: if (bit_done) begin
        n.done = 1'b1;
        n.busy = 1'b0;
        n.st = S_IDLE;
      end
      default: n.st = S_IDLE;
    endcase
    if (fail) begin
      ld = 1'b1;
      ld_rst = 1'b1;
      n.addr = s.addr0;
      if (s.retry == MAX_RETRY) begin
        n.st = S_FIN;
      end else begin
        n.retry = s.retry + 2'h1;
        n.st = S_RST;
      end
    end
    if (ld) begin
      n.sh = ld_val;
      n.bitn = 3'h0;
      n.breq = 1'b1;
      n.bop = ld_rst ? BOP_RESET : ld_rx ? BOP_RD : (ld_val[0] ? BOP_WR1 : BOP_WR0);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign busy     = s.busy;
  assign done     = s.done;
  assign ok       = s.ok;
  assign rd_valid = s.rd_valid;
  assign rd_data  = s.rd_data;
  assign vpp_en   = s.vpp;

  // helper: length of the programming pulse
  logic [16:0] vcnt;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vcnt <= '0;
    end else if (ce) begin
      vcnt <= s.vpp ? vcnt + 17'h1 : 17'h0;
    end
  end

  a_select_first: assert property (@(posedge clk) disable iff (!resetn)
    s.st == S_SEL && s.breq && s.bitn == 3'h0 |-> s.sh == CMD_SKIP_SEL)
    else $error("selection byte wrong");
  a_field_cmd: assert property (@(posedge clk) disable iff (!resetn)
    s.st == S_CMD && s.breq && s.bitn == 3'h0 && s.op == OP_RD_FIELD |-> s.sh == CMD_RD_FIELD)
    else $error("field read code wrong");
  a_lsb_first: assert property (@(posedge clk) disable iff (!resetn)
    s.breq && (s.bop == BOP_WR0 || s.bop == BOP_WR1) |-> s.bop == (s.sh[0] ? BOP_WR1 : BOP_WR0))
    else $error("bit order wrong");
  a_read_after_hdr: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s.st == S_RDAT) |-> $past(s.st) == S_HCRC)
    else $error("data read without header crc");
  a_retry_reset: assert property (@(posedge clk) disable iff (!resetn)
    ce && byte_end && rx && s.st != S_RDAT && !crc_zero && s.retry != MAX_RETRY
    |=> s.st == S_RST && s.breq && s.bop == BOP_RESET)
    else $error("crc mismatch not followed by reset");
  a_write_eight: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s.st == S_DCRC) |-> $past(s.widx) == 3'h7)
    else $error("segment not eight bytes");
  a_stat_one_byte: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s.st == S_HCRC) && s.op == OP_WR_STAT |-> $past(s.st) == S_WDAT)
    else $error("status write data byte missing");
  a_prog_gate: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s.st == S_PCMD) |-> $past(crc_zero)
      && ($past(s.st) == S_DCRC || ($past(s.st) == S_HCRC && s.op == OP_WR_STAT)))
    else $error("program code without crc match");
  a_pulse_len: assert property (@(posedge clk) disable iff (!resetn)
    $fell(s.vpp) |-> vcnt == 17'(PROG_CYC))
    else $error("programming pulse length wrong");
  a_no_drive_pulse: assert property (@(posedge clk) disable iff (!resetn)
    s.vpp |-> !dq_oe)
    else $error("line driven during programming pulse");
  a_wr_align: assert property (@(posedge clk) disable iff (!resetn)
    s.st == S_CMD && s.op == OP_WR_MEM |-> s.addr[2:0] == 3'h0 && s.addr <= WR_ADDR_MAX)
    else $error("write address not aligned or out of range");

  c_read_byte: cover property (@(posedge clk) disable iff (!resetn) s.rd_valid);
  c_write_ok: cover property (@(posedge clk) disable iff (!resetn)
    s.done && s.ok && s.op == OP_WR_MEM);
  c_retry: cover property (@(posedge clk) disable iff (!resetn) $rose(s.retry != 2'h0));
endmodule // oms_seq

// ==== dv/oms_slave.sv ====
/* oms_slave: behavioural single-wire otp slave answering the sequencer.
   assumes the bench clock and a pulled-up line that it can only pull low;
   its cycle counts match slots shortened 25 times (slot 120, reset 200). */
`timescale 1ns/10ps
module oms_slave (
  // clock
  input  logic clk,
  // line
  input  logic dq_oe,
  input  logic vpp_en,
  input  logic crc_bad,
  output logic slave_low
);
  logic [7:0] crc, cmd, alo, ahi, d, pc;
  logic [7:0] bf   [0:7];
  logic [7:0] mem  [0:127];
  logic [7:0] stat [0:7];
  int         low_cnt = 0;
  int         n_sess = 0;
  int         vpp_cnt = 0;
  logic       in_rst = 1'b0;
  event       rst_ev;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    foreach (stat[i]) stat[i] = 8'hff;
    stat[7] = 8'h00;
    slave_low = 1'b0;
  end
  // long low is reset; threshold must outlast a write-0 slot
  always @(posedge clk) begin
    low_cnt <= dq_oe ? low_cnt + 1 : 0;
    if (low_cnt == 160) begin
      in_rst = 1'b1;
      -> rst_ev;
    end
    if (vpp_en) vpp_cnt <= vpp_cnt + 1;
  end
  function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction
  task automatic get_byte(output logic [7:0] b);
    int n;
    for (int i = 0; i < 8; i++) begin
      @(posedge dq_oe);
      n = 0;
      while (dq_oe) begin
        @(posedge clk);
        n++;
      end
      b[i] = (n < 40);
    end
    crc = crc_upd(crc, b);
  endtask
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge dq_oe);
      if (!b[i]) begin
        slave_low = 1'b1;
        repeat (60) @(posedge clk);
        slave_low = 1'b0;
      end
    end
    crc = crc_upd(crc, b);
  endtask
  // reset drops the session, no closing crc
  always @(rst_ev) disable sess;
  always begin : sess
    slave_low = 1'b0;
    wait (in_rst && !dq_oe);
    in_rst = 1'b0;
    // answer pulse over the host sample point
    repeat (40) @(posedge clk);
    slave_low = 1'b1;
    repeat (140) @(posedge clk);
    slave_low = 1'b0;
    n_sess++;
    get_byte(d);
    if (d == 8'hcc) begin
      crc = 8'h00;
      get_byte(cmd);
      get_byte(alo);
      get_byte(ahi);
      if (cmd == 8'h55) get_byte(d);
      // header crc, corrupted only on command
      put_byte(crc_bad ? ~crc : crc);
      crc = 8'h00;
      if (cmd == 8'hf0 || cmd == 8'haa) begin
        // stream to field end then crc
        for (int a = alo; a < (cmd == 8'hf0 ? 128 : 8); a++)
          put_byte(cmd == 8'hf0 ? mem[a] : stat[a]);
        put_byte(crc);
        forever put_byte(8'hff);
      end
      if (cmd == 8'h0f) begin
        foreach (bf[i]) get_byte(bf[i]);
        put_byte(crc);
      end
      get_byte(pc);
      if (pc == 8'h5a) begin
        // count kept past the closing reset so the bench can read it
        vpp_cnt = 0;
        @(negedge vpp_en);
        if (cmd == 8'h0f) foreach (bf[i]) mem[alo + i] = mem[alo + i] & bf[i];
        if (cmd == 8'h55) stat[alo[2:0]] = stat[alo[2:0]] & d;
      end
    end
  end
endmodule // oms_slave

// ==== dv/oms_seq_bench.sv ====
/* oms_seq_bench: runs the sequencer against the slave model.
   assumes shortened reset, program and slot counts; ce is held high. */
`timescale 1ns/10ps
module oms_seq_bench;
  import oms_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  oms_op_t     op = OP_RD_FIELD;
  logic [15:0] addr = 16'h0000;
  logic [63:0] wdata = 64'h0;
  logic        crc_bad = 1'b0;
  logic        busy, done, ok, rd_valid, dq_out, dq_oe, vpp_en, slave_low, dq_line;
  logic [7:0]  rd_data;
  logic [7:0]  got [$];
  int          error_cnt = 0;
  int          checked = 0;
  int          wait_n;
  int          s0;
  logic        was_busy;
  always #10 clk = ~clk;
  assign dq_line = (dq_oe ? dq_out : 1'b1) & ~slave_low;
  always @(negedge clk) if (rd_valid === 1'b1) got.push_back(rd_data);
  oms_seq #(.RESET_LOW_CYC(200), .RESET_HI_CYC(200), .PROG_CYC(100), .TIME_DIV(25)) i_dut (
    .clk(clk), .resetn(resetn), .ce(1'b1), .start(start), .op(op), .addr(addr),
    .wdata(wdata), .busy(busy), .done(done), .ok(ok), .rd_valid(rd_valid),
    .rd_data(rd_data), .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe), .vpp_en(vpp_en));
  oms_slave i_slave (.clk(clk), .dq_oe(dq_oe), .vpp_en(vpp_en), .crc_bad(crc_bad),
    .slave_low(slave_low));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run(input oms_op_t o, input logic [15:0] a, input logic [63:0] w);
    got.delete();
    @(negedge clk);
    op = o;
    addr = a;
    wdata = w;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    was_busy = busy;
    wait_n = 0;
    while (done !== 1'b1 && wait_n < 30000) begin
      @(negedge clk);
      wait_n++;
    end
    if (wait_n == 30000) begin
      error_cnt++;
      $display("mismatch done expected 1 seen timeout");
      end_of_test();
    end
  endtask
  // refused starts never touch the line
  task automatic t_refuse();
    run(OP_WR_MEM, 16'h0003, 64'h0);
    check("misaligned ok", ok, 0);
    check("misaligned fast", wait_n <= 1, 1);
    check("refused busy", was_busy, 0);
    run(OP_WR_MEM, 16'h0080, 64'h0);
    check("high addr fast", wait_n <= 1, 1);
    run(OP_RD_STAT, 16'h0008, 64'h0);
    check("stat addr fast", wait_n <= 1, 1);
    $display("test refuse done");
  endtask
  task automatic t_stat();
    run(OP_WR_STAT, 16'h0006, 64'h3c);
    check("stat write ok", ok, 1);
    check("stat write busy", was_busy, 1);
    check("idle after write", busy, 0);
    check("line released", dq_oe, 0);
    check("stat pulse len", i_slave.vpp_cnt, 100);
    run(OP_RD_STAT, 16'h0005, 64'h0);
    check("stat read ok", ok, 1);
    check("stat count", got.size(), 3);
    check("stat blank", got[0], 8'hff);
    check("stat programmed", got[1], 8'h3c);
    check("stat fixed", got[2], 8'h00);
    $display("test status done");
  endtask
  task automatic t_mem();
    run(OP_WR_MEM, 16'h0078, 64'hff23456789abcdef);
    check("mem write ok", ok, 1);
    check("mem pulse len", i_slave.vpp_cnt, 100);
    run(OP_RD_FIELD, 16'h007e, 64'h0);
    check("field read ok", ok, 1);
    check("field count", got.size(), 2);
    check("field byte 6", got[0], 8'h23);
    check("field byte 7", got[1], 8'hff);
    $display("test memory done");
  endtask
  // header crc is corrupted on every try, so all retries fail
  task automatic t_fault();
    crc_bad = 1'b1;
    s0 = i_slave.n_sess;
    run(OP_RD_STAT, 16'h0007, 64'h0);
    crc_bad = 1'b0;
    check("bad crc ok", ok, 0);
    check("resets seen", i_slave.n_sess - s0, 5);
    check("no bytes", got.size(), 0);
    $display("test crc fault done");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_refuse();
    t_stat();
    t_mem();
    t_fault();
    end_of_test();
  end
endmodule // oms_seq_bench
